// ===== core/preset_table.sv
`timescale 1ns/100ps
`include "speed_sel_defines.svh"
module preset_table #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_idx,
  input  wire logic [15:0]   wr_data,
  input  wire logic [AW-1:0] rd_idx_a,
  output logic      [15:0]   rd_data_a,
  input  wire logic [AW-1:0] rd_idx_b,
  output logic      [15:0]   rd_data_b
);
  logic [15:0] mem_r [DEPTH];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < DEPTH; k++) mem_r[k] <= 16'h0000;
    end else if (wr_en) begin
      mem_r[wr_idx] <= wr_data;
    end
  end
  assign rd_data_a = mem_r[rd_idx_a];
  assign rd_data_b = mem_r[rd_idx_b];
endmodule : preset_table

// ===== core/run_speed_select.sv
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "speed_sel_defines.svh"
module run_speed_select (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  term_in,
  input  wire logic [15:0] analog_freq,
  output logic             run_forward,
  output logic             run_reverse,
  output logic [3:0]       speed_index,
  output logic             preset_active,
  output logic [15:0]      target_freq,
  output logic [15:0]      output_freq_setting
);
  logic [31:0] cfg0_r;
  logic [31:0] cfg1_r;
  logic [15:0] ctl_r;
  logic [15:0] max_freq_r;
  logic [15:0] edit_freq_r;
  logic        store_pulse;
  logic [7:0]  term_lvl;
  logic [7:0]  term_act;
  logic [7:0]  code [8];
  logic        fw_act;
  logic        rv_act;
  logic [3:0]  bin_idx;
  logic [6:0]  sf_bits;
  logic [3:0]  bit_idx;
  logic [3:0]  sel_idx;
  logic        sel_on;
  logic [15:0] tbl_sel;
  logic [15:0] tbl_rd;
  logic [15:0] preset_lim;
  logic        wr_tbl;
  logic        acc;
  logic        mapped;
  speed_sel_pkg::run_dir_e dir_nxt;

  term_sync #(.N(8)) u_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_in    (term_in),
    .level_out (term_lvl)
  );

  assign term_act = term_lvl ^ ctl_r[`CTL_NC_LSB +: 8];

  genvar t;
  generate
    for (t = 0; t < 8; t++) begin : g_code
      if (t < 4) begin : g_lo
        assign code[t] = cfg0_r[t*8 +: 8];
      end else begin : g_hi
        assign code[t] = cfg1_r[(t-4)*8 +: 8];
      end
    end
  endgenerate

  always_comb begin
    fw_act  = 1'b0;
    rv_act  = 1'b0;
    bin_idx = 4'h0;
    sf_bits = 7'h00;
    for (int i = 0; i < 8; i++) begin
      if (code[i] == `FN_FORWARD && term_act[i]) fw_act = 1'b1;
      if (code[i] == `FN_REVERSE && term_act[i]) rv_act = 1'b1;
      for (int b = 0; b < 4; b++) begin
        if (code[i] == `FN_SEL_BIT0 + 8'(b) && term_act[i]) bin_idx[b] = 1'b1;
      end
      for (int b = 0; b < 7; b++) begin
        if (code[i] == `FN_BIT_SF1 + 8'(b) && term_act[i]) sf_bits[b] = 1'b1;
      end
    end
  end
  // unassigned bits stay zero (defaults above)

  always_comb begin
    bit_idx = 4'h0;
    for (int b = 6; b >= 0; b--) begin
      if (sf_bits[b]) bit_idx = 4'(b + 1);
    end
  end

  assign sel_idx = ctl_r[`CTL_METHOD_BIT] ? bit_idx : bin_idx;
  assign sel_on  = ctl_r[`CTL_METHOD_BIT] ? (|sf_bits) : (|bin_idx);

  // keypad direction only for keypad run
  always_comb begin
    if (fw_act && rv_act) begin
      dir_nxt = speed_sel_pkg::DIR_STOP;
    end else if (fw_act) begin
      dir_nxt = speed_sel_pkg::DIR_FORWARD;
    end else if (rv_act) begin
      dir_nxt = speed_sel_pkg::DIR_REVERSE;
    end else if (ctl_r[`CTL_KRUN_BIT]) begin
      dir_nxt = ctl_r[`CTL_KDIR_BIT] ? speed_sel_pkg::DIR_REVERSE
                                     : speed_sel_pkg::DIR_FORWARD;
    end else begin
      dir_nxt = speed_sel_pkg::DIR_STOP;
    end
  end

  // no power-up interlock, level acts at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_forward <= 1'b0;
      run_reverse <= 1'b0;
    end else begin
      run_forward <= (dir_nxt == speed_sel_pkg::DIR_FORWARD);
      run_reverse <= (dir_nxt == speed_sel_pkg::DIR_REVERSE);
    end
  end

  assign wr_tbl = store_pulse && !run_forward && !run_reverse;

  preset_table #(.DEPTH(16), .AW(4)) u_tbl (
    .pclk      (pclk),
    .presetn   (presetn),
    .wr_en     (wr_tbl),
    .wr_idx    (sel_idx),
    .wr_data   (edit_freq_r),
    .rd_idx_a  (sel_idx),
    .rd_data_a (tbl_sel),
    .rd_idx_b  (paddr[5:2]),
    .rd_data_b (tbl_rd)
  );

  assign preset_lim = (tbl_sel > max_freq_r) ? max_freq_r : tbl_sel;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_index   <= 4'h0;
      preset_active <= 1'b0;
      target_freq   <= 16'h0000;
    end else begin
      speed_index   <= sel_idx;
      preset_active <= sel_on && ctl_r[`CTL_SRC_BIT];
      if (ctl_r[`CTL_SRC_BIT] && sel_on) begin
        target_freq <= preset_lim;
      end else begin
        target_freq <= analog_freq;
      end
    end
  end

  // display follows selected slot after store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_freq_setting <= 16'h0000;
    end else if (wr_tbl) begin
      output_freq_setting <= edit_freq_r;
    end else begin
      output_freq_setting <= tbl_sel;
    end
  end

  // apb slave, zero wait states
  assign acc    = psel && penable;
  assign mapped = (paddr <= `REG_ANALOG_FREQ) ||
                  (paddr >= `REG_TABLE_BASE && paddr <= `REG_TABLE_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg0_r      <= `RST_TERM_CFG0;
      cfg1_r      <= `RST_TERM_CFG1;
      ctl_r       <= `RST_CONTROL;
      max_freq_r  <= `RST_MAX_FREQ;
      edit_freq_r <= 16'h0000;
      store_pulse <= 1'b0;
    end else begin
      store_pulse <= 1'b0;
      if (acc && pwrite && paddr[1:0] == 2'b00) begin
        case (paddr)
          `REG_TERM_CFG0: cfg0_r <= pwdata;
          `REG_TERM_CFG1: cfg1_r <= pwdata;
          `REG_CONTROL: begin
            ctl_r       <= pwdata[15:0] & 16'hff0f;
            store_pulse <= pwdata[`CTL_STORE_BIT];
          end
          `REG_MAX_FREQ:  max_freq_r  <= pwdata[15:0];
          `REG_EDIT_FREQ: edit_freq_r <= pwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (!mapped || paddr[1:0] != 2'b00);
      prdata  <= 32'h00000000;
      // a misaligned table read is refused, so its data must stay zero
      if (psel && !penable && !pwrite && paddr[1:0] == 2'b00) begin
        if (paddr >= `REG_TABLE_BASE && paddr <= `REG_TABLE_LAST) begin
          prdata <= {16'h0000, tbl_rd};
        end else begin
          case (paddr)
            `REG_TERM_CFG0:   prdata <= cfg0_r;
            `REG_TERM_CFG1:   prdata <= cfg1_r;
            `REG_CONTROL:     prdata <= {16'h0000, ctl_r};
            `REG_MAX_FREQ:    prdata <= {16'h0000, max_freq_r};
            `REG_EDIT_FREQ:   prdata <= {16'h0000, edit_freq_r};
            `REG_STATUS:      prdata <= {16'h0000, term_act, 1'b0, sel_on,
                                         run_reverse, run_forward, sel_idx};
            `REG_TARGET_FREQ: prdata <= {16'h0000, target_freq};
            `REG_ANALOG_FREQ: prdata <= {16'h0000, analog_freq};
            default:          prdata <= 32'h00000000;
          endcase
        end
      end
    end
  end
endmodule : run_speed_select

// ===== core/speed_sel_defines.svh
`ifndef SPEED_SEL_DEFINES_SVH
`define SPEED_SEL_DEFINES_SVH

// register byte offsets
`define REG_TERM_CFG0    12'h000
`define REG_TERM_CFG1    12'h004
`define REG_CONTROL      12'h008
`define REG_MAX_FREQ     12'h00c
`define REG_EDIT_FREQ    12'h010
`define REG_STATUS       12'h014
`define REG_TARGET_FREQ  12'h018
`define REG_ANALOG_FREQ  12'h01c
`define REG_TABLE_BASE   12'h040
`define REG_TABLE_LAST   12'h07c

// function codes
`define FN_FORWARD       8'h00
`define FN_REVERSE       8'h01
`define FN_SEL_BIT0      8'h02
`define FN_SEL_BIT3      8'h05
`define FN_BIT_SF1       8'h20
`define FN_BIT_SF7       8'h26
`define FN_NONE          8'hff

// control register fields
`define CTL_SRC_BIT      0
`define CTL_METHOD_BIT   1
`define CTL_KDIR_BIT     2
`define CTL_KRUN_BIT     3
`define CTL_STORE_BIT    4
`define CTL_NC_LSB       8

// reset values and frequency width
`define RST_TERM_CFG0    32'h0302ff00
`define RST_TERM_CFG1    32'hffffffff
`define RST_MAX_FREQ     16'd5000
`define RST_CONTROL      16'h0001
`define FREQ_W           16
`endif

// ===== core/speed_sel_pkg.sv
package speed_sel_pkg;
  typedef enum logic [1:0] {
    DIR_STOP    = 2'b00,
    DIR_FORWARD = 2'b01,
    DIR_REVERSE = 2'b11
  } run_dir_e;
  typedef logic [15:0] freq_t;
endpackage : speed_sel_pkg

// ===== core/term_sync.sv
`timescale 1ns/100ps
`include "speed_sel_defines.svh"
module term_sync #(
  parameter int N = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [N-1:0] pin_in,
  output logic      [N-1:0] level_out
);
  logic [N-1:0] s1_r;
  logic [N-1:0] s2_r;
  logic [N-1:0] s3_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // a change counts once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          level_out[i] <= 1'b0;
        end else if (s2_r[i] == s3_r[i]) begin
          level_out[i] <= s3_r[i];
        end
      end
    end
  endgenerate
endmodule : term_sync

// ===== dv/run_and_binary_speed_select_tb.sv
`timescale 1ns/100ps
`include "speed_sel_defines.svh"
module run_and_binary_speed_select_tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0]  sw = 8'h01, term_in;
  logic [15:0] analog_freq = 16'h1234, target_freq, output_freq_setting;
  logic [3:0]  speed_index;
  logic [1:0]  run;
  logic        pready, pslverr, err, run_forward, run_reverse, preset_active;
  int          mismatches = 0, comparisons = 0;
  assign run = {run_forward, run_reverse};
  always #4 pclk = ~pclk;
  term_switches i_term_switches (.pclk(pclk), .closed(sw), .term_in(term_in));
  run_speed_select i_run_speed_select (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .term_in(term_in), .analog_freq(analog_freq),
    .run_forward(run_forward), .run_reverse(run_reverse), .speed_index(speed_index),
    .preset_active(preset_active), .target_freq(target_freq),
    .output_freq_setting(output_freq_setting));

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      mismatches++;
      end_sim();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb

  // contacts need the synchroniser and one decode edge before they show
  task automatic step(input logic [7:0] s);
    sw <= s;
    repeat (8) @(posedge pclk);
  endtask : step

  task automatic t_run;
    logic [7:0] s[6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h00, 8'h03};
    logic [1:0] e[6] = '{2'b00, 2'b10, 2'b01, 2'b00, 2'b01, 2'b10};
    step(8'h01);
    chk("pwrup", 32'h2, 32'(run));
    apb(1'b0, `REG_TERM_CFG0, 32'h0);
    chk("cfg0", `RST_TERM_CFG0, rd);
    apb(1'b0, 12'h030, 32'h0);
    chk("unmap", 32'h1, 32'(err));
    apb(1'b1, `REG_TERM_CFG0, 32'hffff0100);
    for (int i = 0; i < 6; i++) begin
      // normally closed on terminal 1, keypad direction reverse
      if (i == 4) apb(1'b1, `REG_CONTROL, 32'h204);
      step(s[i]);
      chk("run", 32'(e[i]), 32'(run));
    end
    // keypad run in reverse only while no terminal asks for a direction
    apb(1'b1, `REG_CONTROL, 32'h0c);
    step(8'h00);
    chk("krun", 32'h1, 32'(run));
    step(8'h01);
    chk("kterm", 32'h2, 32'(run));
    $display("test run done");
  endtask : t_run

  task automatic t_bin;
    logic [3:0] n;
    apb(1'b1, `REG_TERM_CFG1, 32'h02030405);
    apb(1'b1, `REG_CONTROL, 32'h1);
    // the table only takes values by store, with run off
    for (int i = 0; i < 16; i++) begin
      n = 4'(i);
      step({n[0], n[1], n[2], n[3], 4'h0});
      apb(1'b1, `REG_EDIT_FREQ, 32'(100 * i + 7));
      apb(1'b1, `REG_CONTROL, 32'h11);
    end
    for (int i = 0; i < 16; i++) begin
      n = 4'(i);
      step({n[0], n[1], n[2], n[3], 4'h1});
      chk("idx", 32'(n), 32'(speed_index));
      chk("act", (i == 0) ? 32'h0 : 32'h1, 32'(preset_active));
      chk("tgt", (i == 0) ? 32'h1234 : 32'(100 * i + 7), 32'(target_freq));
    end
    step(8'hf0);
    apb(1'b1, `REG_EDIT_FREQ, 32'd6000);
    apb(1'b1, `REG_CONTROL, 32'h11);
    step(8'hf1);
    chk("clip", 32'd5000, 32'(target_freq));
    apb(1'b1, `REG_MAX_FREQ, 32'd7000);
    step(8'hf1);
    chk("raise", 32'd6000, 32'(target_freq));
    apb(1'b1, `REG_TERM_CFG1, 32'hffffff02);
    step(8'hf1);
    chk("unasg", 32'h1, 32'(speed_index));
    $display("test binary done");
  endtask : t_bin

  task automatic t_store;
    // programming through the selects happens only with run off
    step(8'h10);
    apb(1'b1, `REG_EDIT_FREQ, 32'h0abc);
    apb(1'b0, `REG_TABLE_BASE + 12'h004, 32'h0);
    chk("nostore", 32'd107, rd);
    apb(1'b1, `REG_CONTROL, 32'h11);
    apb(1'b0, `REG_TABLE_BASE + 12'h004, 32'h0);
    chk("store", 32'h0abc, rd);
    chk("disp", 32'h0abc, 32'(output_freq_setting));
    apb(1'b0, `REG_TABLE_BASE + 12'h006, 32'h0);
    chk("misal", 32'h0, rd);
    chk("misalerr", 32'h1, 32'(err));
    step(8'h11);
    apb(1'b1, `REG_EDIT_FREQ, 32'h0def);
    apb(1'b1, `REG_CONTROL, 32'h11);
    apb(1'b0, `REG_TABLE_BASE + 12'h004, 32'h0);
    chk("runstore", 32'h0abc, rd);
    apb(1'b1, `REG_TERM_CFG1, 32'h23222120);
    apb(1'b1, `REG_CONTROL, 32'h3);
    step(8'h60);
    chk("sfidx", 32'h2, 32'(speed_index));
    $display("test store done");
  endtask : t_store

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_run();
    t_bin();
    t_store();
    end_sim();
  end
endmodule : run_and_binary_speed_select_tb

// ===== dv/run_speed_select_checker.sv
`timescale 1ns/100ps
module run_speed_select_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  term_in,
  input wire logic [15:0] analog_freq,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        run_forward,
  input wire logic        run_reverse,
  input wire logic [3:0]  speed_index,
  input wire logic        preset_active,
  input wire logic [15:0] target_freq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // eight quiet cycles cover the synchroniser and decode pipeline
  sequence quiet8;
    (!psel && $stable(term_in) && $stable(analog_freq)) [*8];
  endsequence
  AST_NO_BOTH: assert property (!(run_forward && run_reverse))
    else $error("both run outputs high");
  AST_ACT_IDX: assert property (preset_active |-> speed_index != 4'h0)
    else $error("preset active with index zero");
  AST_RUN_HOLD: assert property (quiet8 |-> $stable({run_forward, run_reverse}))
    else $error("run moved without cause");
  AST_IDX_HOLD: assert property (quiet8 |-> $stable({speed_index, preset_active}))
    else $error("index moved without cause");
  AST_TGT_HOLD: assert property (quiet8 |-> $stable(target_freq))
    else $error("target moved without cause");
  AST_RDY_SETUP: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_RDY_PULSE: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside access");
  AST_ERR_RD: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("refused read with data");
  COV_FWD: cover property (run_forward);
  COV_REV: cover property (run_reverse);
  COV_TOP: cover property (preset_active && speed_index == 4'hf);
endmodule : run_speed_select_checker

bind run_speed_select run_speed_select_checker i_run_speed_select_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .term_in(term_in), .analog_freq(analog_freq), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .run_forward(run_forward), .run_reverse(run_reverse),
  .speed_index(speed_index), .preset_active(preset_active), .target_freq(target_freq));

// ===== dv/term_switches.sv
`timescale 1ns/100ps
// switch bank: a closed contact puts field voltage on its terminal
module term_switches (
  input  wire logic       pclk,
  input  wire logic [7:0] closed,
  output logic      [7:0] term_in
);
  // contacts move just after an edge, never on it
  always_ff @(posedge pclk) begin
    term_in <= closed;
  end
endmodule : term_switches
